// file: include/tss_pkg.sv
// Package for the trace status register: field layout, reset values, encodings
package tss_pkg;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TSS_MODES_LSB  = 5;
    localparam int TSS_MODES_MSB  = 6;
    localparam int TSS_COUNT_BIT  = 4;
    localparam int TSS_INUSE_BIT  = 3;
    localparam int TSS_SYNC_LSB   = 0;
    localparam int TSS_SYNC_MSB   = 2;
    localparam int TSS_RSVD_LSB   = 7;
    localparam int TSS_RSVD_MSB   = 31;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0] TSS_MODES_PC_ONLY = 2'h0;
    localparam logic [1:0] TSS_MODES_ADDR    = 2'h1;
    localparam logic [1:0] TSS_MODES_DATA    = 2'h2;
    localparam logic [1:0] TSS_MODES_RSVD    = 2'h3;
    localparam logic [1:0] TSS_MODES_RESET   = 2'h2;
    localparam logic [2:0] TSS_SYNC_RESET    = 3'h0;
    localparam logic       TSS_INUSE_RESET   = 1'b0;
    localparam logic       TSS_COUNT_RESET   = 1'b0;
    localparam logic       TSS_BUF_ONCHIP    = 1'b0;
    localparam logic       TSS_BUF_OFFCHIP   = 1'b1;

    // Exponent offsets of the sync period for each buffer kind
    localparam logic [3:0] TSS_SYNC_EXP_ON   = 4'h2;
    localparam logic [3:0] TSS_SYNC_EXP_OFF  = 4'h7;
    localparam int         TSS_PERIOD_W      = 15;

    // ************************************************************
    // Carrier from the trace control unit
    // ************************************************************
    typedef struct packed {
        logic       buffer_count_flag;
        logic       buffer_in_use;
        logic [2:0] sync_period;
    } tss_tcu_cfg_t;

endpackage

// file: rtl/tss_period_dec.sv
// Decoder from sync period code and buffer choice to a cycle count
`timescale 1ns/1ps
module tss_period_dec #(
    parameter int PERIOD_W = tss_pkg::TSS_PERIOD_W
) (
    // Code in
    input  wire logic [2:0]          code_i,
    input  wire logic                offchip_i,
    // Period out
    output logic      [PERIOD_W-1:0] period_o
);
    wire logic [3:0] exp_w;

    assign exp_w = {1'b0, code_i} + (offchip_i ? tss_pkg::TSS_SYNC_EXP_OFF
                                               : tss_pkg::TSS_SYNC_EXP_ON);
    assign period_o = PERIOD_W'(1) << exp_w;
endmodule

// file: rtl/tss_status_reg.sv
// Trace status register: read-only capability and configuration word
//
// How it works
// - Reserved upper bits read as zero.
// - Supported modes at bits 6:5, reset 10.
// - Modes: PC, plus addresses, plus data, reserved.
// - Bit 4 says one or two buffers.
// - Bit 3 shows the buffer being written.
// - On-chip sync period is two to code+2.
// - Off-chip sync period is two to code+7.
// - Unit-supplied fields invalid until unit asserts them.
// - Register exists only with trace option present.
`timescale 1ns/1ps
module tss_status_reg #(
    parameter bit         TRACE_PRESENT = 1'b1,
    parameter logic [1:0] MODES_VALUE   = tss_pkg::TSS_MODES_RESET,
    parameter int         PERIOD_W      = tss_pkg::TSS_PERIOD_W
) (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    // Trace control unit
    input  wire tss_pkg::tss_tcu_cfg_t tcu_cfg_i,
    input  wire logic                  tcu_cfg_valid_i,
    // Register read port
    input  wire logic                  rd_en_i,
    output logic      [31:0]           rd_data_o,
    output logic                       present_o,
    // Status
    output logic                       cfg_valid_o,
    output logic      [PERIOD_W-1:0]   sync_cycles_o
);
    // ************************************************************
    // Captured configuration
    // ************************************************************
    tss_pkg::tss_tcu_cfg_t cfg_reg;
    logic                  valid_reg;
    logic [1:0]            modes_reg;
    logic [31:0]           rd_data_reg;
    logic [PERIOD_W-1:0]   period_reg;
    logic                  present_reg;
    wire logic [PERIOD_W-1:0] period_next;
    wire logic [PERIOD_W-1:0] period_sel;
    wire logic [31:0]         word_next;

    // Fields capture the unit word only on cycles it asserts valid, and hold in between
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg   <= '0;
            valid_reg <= 1'b0;
            modes_reg <= tss_pkg::TSS_MODES_RESET;
        end else if (ce_i) begin
            modes_reg <= MODES_VALUE;
            if (tcu_cfg_valid_i) begin
                cfg_reg   <= tcu_cfg_i;
                valid_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Sync period
    // ************************************************************
    // Decoded from the captured code, so unit bus glitches never show
    tss_period_dec #(
        .PERIOD_W (PERIOD_W)
    ) u_dec (
        .code_i    (cfg_reg.sync_period),
        .offchip_i (cfg_reg.buffer_in_use),
        .period_o  (period_next)
    );

    // Zero until the unit has spoken; the code means nothing before
    assign period_sel = valid_reg ? period_next : '0;

    // ************************************************************
    // Read word
    // ************************************************************
    // Reserved bits are tied low so later fields can be added safely
    assign word_next = TRACE_PRESENT ? {25'h0000000,
                                        modes_reg,
                                        cfg_reg.buffer_count_flag,
                                        cfg_reg.buffer_in_use,
                                        cfg_reg.sync_period}
                                     : 32'h00000000;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_reg <= 32'h00000000;
            period_reg  <= '0;
            present_reg <= TRACE_PRESENT;
        end else if (ce_i) begin
            if (rd_en_i) begin
                rd_data_reg <= word_next;
            end
            period_reg  <= period_sel;
            present_reg <= TRACE_PRESENT;
        end
    end

    assign rd_data_o     = rd_data_reg;
    assign present_o     = present_reg;
    assign cfg_valid_o   = valid_reg;
    assign sync_cycles_o = period_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_rsvd_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        rd_data_o[31:7] == 25'h0000000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

    property p_modes;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_en_i && TRACE_PRESENT) |=> rd_data_o[6:5] == MODES_VALUE;
    endproperty
    a_modes: assert property (p_modes) else $error("modes field wrong");

    property p_modes_legal;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_en_i) |=> rd_data_o[6:5] != tss_pkg::TSS_MODES_RSVD;
    endproperty
    a_modes_legal: assert property (p_modes_legal) else $error("reserved mode code");

    property p_fields;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_en_i && TRACE_PRESENT) |=> rd_data_o[4:0] == $past(cfg_reg);
    endproperty
    a_fields: assert property (p_fields) else $error("unit fields wrong");

    property p_capture;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && tcu_cfg_valid_i) |=> cfg_reg.buffer_in_use == $past(tcu_cfg_i.buffer_in_use);
    endproperty
    a_capture: assert property (p_capture) else $error("buffer bit not captured");

    property p_onchip;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && valid_reg && !cfg_reg.buffer_in_use)
        |=> sync_cycles_o == (PERIOD_W'(1) << ($past(cfg_reg.sync_period) + 2));
    endproperty
    a_onchip: assert property (p_onchip) else $error("on-chip period wrong");

    property p_offchip;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && valid_reg && cfg_reg.buffer_in_use)
        |=> sync_cycles_o == (PERIOD_W'(1) << ($past(cfg_reg.sync_period) + 7));
    endproperty
    a_offchip: assert property (p_offchip) else $error("off-chip period wrong");

    property p_invalid;
        @(posedge clk_sys_i) disable iff (rst_i)
        !valid_reg |-> sync_cycles_o == '0;
    endproperty
    a_invalid: assert property (p_invalid) else $error("period before valid");

    property p_absent;
        @(posedge clk_sys_i) disable iff (rst_i)
        !TRACE_PRESENT |-> rd_data_o == 32'h00000000;
    endproperty
    a_absent: assert property (p_absent) else $error("absent register reads nonzero");

    property p_present;
        @(posedge clk_sys_i) disable iff (rst_i)
        present_o == TRACE_PRESENT;
    endproperty
    a_present: assert property (p_present) else $error("presence flag wrong");

    property p_inuse_read;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_en_i && TRACE_PRESENT)
        |=> rd_data_o[tss_pkg::TSS_INUSE_BIT] == $past(cfg_reg.buffer_in_use);
    endproperty
    a_inuse_read: assert property (p_inuse_read) else $error("buffer bit misread");

    property p_sync_read;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_en_i && TRACE_PRESENT) |=> rd_data_o[2:0] == $past(cfg_reg.sync_period);
    endproperty
    a_sync_read: assert property (p_sync_read) else $error("sync code misread");

    property p_invalid_read;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_en_i && !valid_reg) |=> rd_data_o[4:0] == 5'h00;
    endproperty
    a_invalid_read: assert property (p_invalid_read) else $error("fields before valid");

    property p_rd_hold;
        @(posedge clk_sys_i) disable iff (rst_i)
        !(ce_i && rd_en_i) |=> $stable(rd_data_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read word moved unasked");

    // ************************************************************
    // Checks on the unit handover, the clock-enable freeze and the period shape
    // ************************************************************
    property p_valid_set;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && tcu_cfg_valid_i) |=> cfg_valid_o;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("valid not raised");

    property p_valid_hold;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_valid_o |=> cfg_valid_o;
    endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("valid dropped");

    property p_freeze;
        @(posedge clk_sys_i) disable iff (rst_i)
        !ce_i |=> $stable(rd_data_o) && $stable(cfg_valid_o) && $stable(sync_cycles_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_onehot;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && valid_reg) |=> $onehot(sync_cycles_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("period not a power of two");

    // ************************************************************
    // Cover
    // ************************************************************
    c_valid:   cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(valid_reg));
    c_offchip: cover property (@(posedge clk_sys_i) disable iff (rst_i)
                               valid_reg && cfg_reg.buffer_in_use);
    c_read:    cover property (@(posedge clk_sys_i) disable iff (rst_i) ce_i && rd_en_i);
    c_onchip:  cover property (@(posedge clk_sys_i) disable iff (rst_i)
                               valid_reg && !cfg_reg.buffer_in_use);
    c_frozen:  cover property (@(posedge clk_sys_i) disable iff (rst_i)
                               !ce_i && tcu_cfg_valid_i);
endmodule

// file: verification/tss_tcu_model.sv
// Trace unit model: hands over buffer configuration after a chosen delay
`timescale 1ns/1ps
module tss_tcu_model (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    // Bench request
    input  wire logic                  req_i,
    input  wire tss_pkg::tss_tcu_cfg_t req_cfg_i,
    input  wire logic [3:0]            lat_i,
    // Toward the register
    output tss_pkg::tss_tcu_cfg_t      cfg_o,
    output logic                       valid_o
);
    tss_pkg::tss_tcu_cfg_t held_reg;
    logic [3:0]            cnt_reg;
    logic                  pend_reg;
    // Inverse when not asserted, so a stale value never passes
    assign cfg_o = valid_o ? held_reg : ~held_reg;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0;
            valid_o  <= 1'b0;
            cnt_reg  <= 4'h0;
            held_reg <= '0;
        end else if (req_i) begin
            pend_reg <= 1'b1;
            cnt_reg  <= lat_i;
            held_reg <= req_cfg_i;
            valid_o  <= 1'b0;
        end else begin
            valid_o  <= pend_reg && cnt_reg == 4'h0;
            pend_reg <= pend_reg && cnt_reg != 4'h0;
            cnt_reg  <= cnt_reg - {3'h0, pend_reg && cnt_reg != 4'h0};
        end
    end
endmodule

// file: verification/trace_status_register_tb.sv
// Bench for the trace status register with a trace unit model
`timescale 1ns/1ps
module trace_status_register_tb;
    logic                  clk_sys_i = 1'b0;
    logic                  rst_i     = 1'b1;
    logic                  ce_i      = 1'b1;
    logic                  rd_en_i   = 1'b0;
    logic                  req       = 1'b0;
    logic [3:0]            lat       = 4'h0;
    tss_pkg::tss_tcu_cfg_t req_cfg   = '0;
    tss_pkg::tss_tcu_cfg_t cfg;
    logic                  tcu_valid;
    logic                  cfg_valid;
    logic                  present;
    logic [31:0]           rd_data;
    logic [31:0]           rd_data_abs;
    logic                  present_abs;
    logic [14:0]           sync_cycles;
    int                    mismatches = 0;
    int                    checks     = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    tss_tcu_model tcu (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req),
        .req_cfg_i(req_cfg), .lat_i(lat), .cfg_o(cfg), .valid_o(tcu_valid));
    tss_status_reg dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .tcu_cfg_i(cfg), .tcu_cfg_valid_i(tcu_valid), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data), .present_o(present), .cfg_valid_o(cfg_valid),
        .sync_cycles_o(sync_cycles));
    // Copy built without the trace option, fed the same stimulus
    tss_status_reg #(.TRACE_PRESENT(1'b0)) dut_absent (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .ce_i(ce_i), .tcu_cfg_i(cfg), .tcu_cfg_valid_i(tcu_valid), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_abs), .present_o(present_abs), .cfg_valid_o(),
        .sync_cycles_o());

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd();
        @(negedge clk_sys_i) rd_en_i = 1'b1;
        @(negedge clk_sys_i) rd_en_i = 1'b0;
    endtask

    // Latency follows the code, so the unit answers both promptly and slowly
    task automatic load(input logic f, u, input logic [2:0] c);
        @(negedge clk_sys_i) req = 1'b1;
        req_cfg = '{f, u, c};
        lat = {1'b0, c};
        @(negedge clk_sys_i) req = 1'b0;
        for (int i = 0; i < 12 && tcu_valid !== 1'b1; i++) @(negedge clk_sys_i);
        repeat (2) @(negedge clk_sys_i);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        rd();
        chk("word", rd_data, 32'h00000040);
        chk("modes", 32'(rd_data[6:5]), 32'(tss_pkg::TSS_MODES_DATA));
        chk("valid", 32'(cfg_valid), 32'h0);
        chk("present", 32'(present), 32'h1);
        chk("absent word", rd_data_abs, 32'h0);
        chk("absent flag", 32'(present_abs), 32'h0);
        // The advertised modes field never reads back as the reserved code
        chk("mode legal", 32'(rd_data[6:5] != tss_pkg::TSS_MODES_RSVD), 32'h1);
        for (int u = 0; u < 2; u++) begin
            for (int c = 0; c < 8; c++) begin
                load(1'b1, u[0], c[2:0]);
                rd();
                chk("word", rd_data, {25'h0, 2'h2, 1'b1, u[0], c[2:0]});
                chk("period", 32'(sync_cycles), 32'h1 << (c + (u * 5) + 2));
                chk("valid", 32'(cfg_valid), 32'h1);
            end
        end
        // Unit config while frozen must not land
        ce_i = 1'b0;
        load(1'b0, 1'b0, 3'h1);
        ce_i = 1'b1;
        rd();
        chk("frozen", rd_data, 32'h0000005F);
        @(negedge clk_sys_i) rst_i = 1'b1;
        @(negedge clk_sys_i) rst_i = 1'b0;
        chk("reset", 32'({cfg_valid, sync_cycles}), 32'h0);
        rd();
        chk("reset word", rd_data, 32'h00000040);
        load(1'b0, 1'b0, 3'h3);
        rd();
        chk("single buffer", rd_data, 32'h00000043);
        chk("short period", 32'(sync_cycles), 32'h00000020);
        chk("absent after", rd_data_abs, 32'h0);
        test_done();
    end

    initial begin
        #20000;
        mismatches++;
        test_done();
    end
endmodule
